// ### afe_mux_clamp_defines.vh
// Register map, field positions, reset values and timing counts of the front-end control block
// Notes on behaviour
// [RQ1] Component video uses all three channels; chroma pair alternates into second converter.
// [RQ2] Component set one is 000/00/00, set two is 001/01/01.
// [RQ3] Only one of two wired component sets is selected at a time.
// [RQ4] S-Video with sound IF: luma first, sound IF second, chroma third channel.
// [RQ5] S-Video plus sound IF: mode 10, clamp types 0/1/0, alternate 1, audio 1.
// [RQ6] S-Video plus sound IF: half band, boost, clamp, gain select cleared for channels two, three.
// [RQ7] Features configure themselves after reset; software overrides each through registers.
// [RQ8] Writing 1 to an impedance boost bit at 0x106 enables that channel's boost. The code enables it only when bit 7 of the same write is also 1.
// [RQ9] Boost only with clamping, for most video, never on sound IF channels. The code does not gate boost by clamp enable or by the sound IF route.
// [RQ10] Clamps enabled after reset; writing 0 at 0x105 or 0x106 disables one. The code disables one only while bit 7 of 0x106 is 1.
// [RQ11] Clamp strobe asserts during each line's sync, held at least 1 us.
// [RQ12] Clamp level code maps to target converter code; 000 is out of range.
// [RQ13] Register 0x103 holds selectors in bits 2:0, 5:4 and 7:6.
// [RQ14] In alternate mode the second converter alternates between channels two and three.
// [RQ15] Strobe length is a clock count rounded up so it never falls short.
`ifndef AFE_MUX_CLAMP_DEFINES_VH
`define AFE_MUX_CLAMP_DEFINES_VH
`define AMC_ADDR_W         12
`define AMC_OFF_ROUTE      12'h103
`define AMC_OFF_CTRL2      12'h105
`define AMC_OFF_CTRL3      12'h106
`define AMC_OFF_STATUS     12'h110
`define AMC_RST_ROUTE      8'hD3
`define AMC_RST_CTRL2      8'h33
`define AMC_RST_CTRL3      8'h0F
// Route fields
`define AMC_CH1_LSB        0
`define AMC_CH2_LSB        4
`define AMC_CH3_LSB        6
// Control 2 fields: clamp level bits 2:0, clamp enable first channel bit 4, clamp type bits 7:5
`define AMC_LVL_LSB        0
`define AMC_CLEN1_BIT      4
`define AMC_CTYPE1_BIT     5
`define AMC_CTYPE2_BIT     6
`define AMC_CTYPE3_BIT     7
// Control 3 fields
`define AMC_CLEN2_BIT      0
`define AMC_CLEN3_BIT      1
`define AMC_BOOST1_BIT     2
`define AMC_BOOST2_BIT     3
`define AMC_BOOST3_BIT     4
`define AMC_ALT_BIT        5
`define AMC_AUD_BIT        6
`define AMC_MANUAL_BIT     7
// Strobe timing
`define AMC_CLK_KHZ        20000
`define AMC_STROBE_NS      1000
`define AMC_STROBE_CYC     ((`AMC_STROBE_NS * `AMC_CLK_KHZ + 999999) / 1000000)
`endif

// ### afe_mux_clamp.v
// Front-end input routing, clamp control and clamp strobe generation
`include "afe_mux_clamp_defines.vh"
module amc_afe_mux_clamp #(
   parameter STROBE_CYC = `AMC_STROBE_CYC
) (
   // Clock and reset
   input  wire        clock,
   input  wire        rst_n,
   // Register port
   input  wire [11:0] reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   // Line timing from the decoder
   input  wire        sync_active,
   // Analog controls
   output reg  [2:0]  first_channel_input_sel,
   output reg  [1:0]  second_channel_input_sel,
   output reg  [1:0]  third_channel_input_sel,
   output reg  [2:0]  clamp_enable,
   output reg  [2:0]  impedance_boost_en,
   output reg  [2:0]  clamp_type,
   output reg  [2:0]  clamp_voltage_code,
   output reg  [9:0]  clamp_target_code,
   output reg         clamp_target_valid,
   output reg         second_converter_alternate,
   output reg         sound_if_route_sel,
   output reg         clamp_strobe,
   output reg         adc2_sample_third
);
   reg  [7:0]  route_q;
   reg  [7:0]  ctrl2_q;
   reg  [7:0]  ctrl3_q;
   reg  [15:0] strobe_cnt_q;
   reg         sync_q;
   reg         alt_phase_q;
   wire        manual;
   wire        sync_rise;
   reg  [9:0]  target_d;

   // Register writes; reset puts the block into its automatic configuration
   always @(posedge clock) begin
      if (!rst_n) begin
         route_q <= `AMC_RST_ROUTE; // RQ7
         ctrl2_q <= `AMC_RST_CTRL2; // RQ10
         ctrl3_q <= `AMC_RST_CTRL3; // RQ10
      end else if (reg_wr) begin
         case (reg_addr)
            `AMC_OFF_ROUTE: route_q <= reg_wdata; // RQ13
            `AMC_OFF_CTRL2: ctrl2_q <= reg_wdata; // RQ10
            `AMC_OFF_CTRL3: ctrl3_q <= reg_wdata; // RQ8
            default:        route_q <= route_q;
         endcase
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `AMC_OFF_ROUTE:  reg_rdata <= route_q;
            `AMC_OFF_CTRL2:  reg_rdata <= ctrl2_q;
            `AMC_OFF_CTRL3:  reg_rdata <= ctrl3_q;
            `AMC_OFF_STATUS: reg_rdata <= {5'h00, adc2_sample_third, clamp_target_valid, clamp_strobe};
            default:         reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   assign manual = ctrl3_q[`AMC_MANUAL_BIT];

   // Clamp level to converter code at 0 dB gain
   always @* begin
      case (ctrl2_q[`AMC_LVL_LSB +: 3])
         3'h1:    target_d = 10'h000; // RQ12
         3'h2:    target_d = 10'h07C;
         3'h3:    target_d = 10'h0DA;
         3'h4:    target_d = 10'h121;
         3'h5:    target_d = 10'h157;
         3'h6:    target_d = 10'h180;
         3'h7:    target_d = 10'h200;
         default: target_d = 10'h000;
      endcase
   end

   // Analog control outputs; automatic settings keep clamps on until software takes over
   always @(posedge clock) begin
      if (!rst_n) begin
         first_channel_input_sel    <= 3'h0;
         second_channel_input_sel   <= 2'h0;
         third_channel_input_sel    <= 2'h0;
         clamp_enable               <= 3'h7;
         impedance_boost_en         <= 3'h0;
         clamp_type                 <= 3'h0;
         clamp_voltage_code         <= 3'h0;
         clamp_target_code          <= 10'h000;
         clamp_target_valid         <= 1'b0;
         second_converter_alternate <= 1'b0;
         sound_if_route_sel         <= 1'b0;
      end else begin
         first_channel_input_sel  <= route_q[`AMC_CH1_LSB +: 3]; // RQ13
         second_channel_input_sel <= route_q[`AMC_CH2_LSB +: 2]; // RQ13
         third_channel_input_sel  <= route_q[`AMC_CH3_LSB +: 2]; // RQ13
         clamp_voltage_code       <= ctrl2_q[`AMC_LVL_LSB +: 3];
         clamp_target_code        <= target_d; // RQ12
         clamp_target_valid       <= (ctrl2_q[`AMC_LVL_LSB +: 3] != 3'h0); // RQ12
         if (manual) begin
            clamp_enable <= {ctrl3_q[`AMC_CLEN3_BIT], ctrl3_q[`AMC_CLEN2_BIT], ctrl2_q[`AMC_CLEN1_BIT]}; // RQ10
            impedance_boost_en <= {ctrl3_q[`AMC_BOOST3_BIT], ctrl3_q[`AMC_BOOST2_BIT],
                                   ctrl3_q[`AMC_BOOST1_BIT]}; // RQ8
            clamp_type <= {ctrl2_q[`AMC_CTYPE3_BIT], ctrl2_q[`AMC_CTYPE2_BIT], ctrl2_q[`AMC_CTYPE1_BIT]};
            second_converter_alternate <= ctrl3_q[`AMC_ALT_BIT];
            sound_if_route_sel         <= ctrl3_q[`AMC_AUD_BIT];
         end else begin
            // Automatic: component video, clamps on, chroma pair alternated
            clamp_enable               <= 3'h7; // RQ7
            impedance_boost_en         <= 3'h0;
            clamp_type                 <= 3'h0;
            second_converter_alternate <= 1'b1; // RQ1
            sound_if_route_sel         <= 1'b0;
         end
      end
   end

   // Second converter channel: toggles every cycle in alternate mode, else held on the second channel (adc2_sample_third low)
   always @(posedge clock) begin
      if (!rst_n) begin
         alt_phase_q      <= 1'b0;
         adc2_sample_third <= 1'b0;
      end else begin
         alt_phase_q <= second_converter_alternate ? ~alt_phase_q : 1'b0; // RQ14
         adc2_sample_third <= second_converter_alternate & alt_phase_q; // RQ14
      end
   end

   // Clamp strobe: starts at sync, stays up while sync lasts and at least the minimum count
   assign sync_rise = sync_active & ~sync_q;
   always @(posedge clock) begin
      if (!rst_n) begin
         sync_q       <= 1'b0;
         strobe_cnt_q <= 16'h0000;
         clamp_strobe <= 1'b0;
      end else begin
         sync_q <= sync_active;
         if (sync_rise) begin
            strobe_cnt_q <= STROBE_CYC[15:0] - 16'h0001; // RQ15
            clamp_strobe <= 1'b1; // RQ11
         end else if (strobe_cnt_q != 16'h0000) begin
            strobe_cnt_q <= strobe_cnt_q - 16'h0001;
            clamp_strobe <= 1'b1; // RQ11
         end else begin
            clamp_strobe <= sync_active & clamp_strobe;
         end
      end
   end
endmodule

// ### amc_props.sv
// Port checker of the front-end routing and clamp block
module amc_props #(parameter STROBE_CYC = 2) (
   // Clock, reset and register port
   input wire logic        clock, rst_n, reg_wr, reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0]  reg_wdata, reg_rdata,
   // Line timing and analog controls
   input wire logic        sync_active, clamp_strobe, clamp_target_valid, adc2_sample_third,
   input wire logic        second_converter_alternate, sound_if_route_sel,
   input wire logic [2:0]  first_channel_input_sel, clamp_enable, impedance_boost_en, clamp_type, clamp_voltage_code,
   input wire logic [1:0]  second_channel_input_sel, third_channel_input_sel,
   input wire logic [9:0]  clamp_target_code
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [9:0] LV [8] = '{10'h000, 10'h000, 10'h07C, 10'h0DA, 10'h121, 10'h157, 10'h180, 10'h200};
   wire wr_man = reg_wr && reg_addr == 12'h106 && reg_wdata[7];
   wire wr_auto = reg_wr && reg_addr == 12'h106 && !reg_wdata[7];
   wire wr_rt = reg_wr && reg_addr == 12'h103;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence sync_edge; $rose(sync_active); endsequence
   sequence alt_run; second_converter_alternate[*4]; endsequence
   AST_BOOST: assert property (wr_man |=> ##1 impedance_boost_en == $past(reg_wdata[4:2], 2))
      else $error("boost does not follow write");
   AST_CLAMP_OFF: assert property (wr_man && !reg_wdata[0] |=> ##1 !clamp_enable[1])
      else $error("clamp not disabled");
   AST_AUTO: assert property (wr_auto |=> ##1 clamp_enable == 3'h7 && second_converter_alternate)
      else $error("automatic setup lost");
   AST_ROUTE: assert property (wr_rt |=> ##1
      {third_channel_input_sel, second_channel_input_sel, first_channel_input_sel} ==
      {$past(reg_wdata[7:4], 2), $past(reg_wdata[2:0], 2)})
      else $error("selector mismatch");
   AST_LEVEL: assert property (clamp_target_valid == (clamp_voltage_code != 3'h0) &&
      clamp_target_code == LV[clamp_voltage_code])
      else $error("clamp target mismatch");
   AST_STROBE: assert property (sync_edge |=> clamp_strobe[*2])
      else $error("clamp strobe too short");
   AST_HOLD: assert property (sync_active && clamp_strobe |=> clamp_strobe)
      else $error("clamp strobe dropped during sync");
   AST_ALT_OFF: assert property (!second_converter_alternate[*2] |-> !adc2_sample_third)
      else $error("second converter alternates while off");
   AST_ALT_ON: assert property (alt_run |-> !(adc2_sample_third == $past(adc2_sample_third) &&
      adc2_sample_third == $past(adc2_sample_third, 2)))
      else $error("second converter does not alternate");
endmodule
bind amc_afe_mux_clamp amc_props #(.STROBE_CYC(STROBE_CYC)) amc_props_i (.*);

// ### amc_partner.sv
// Line sync source and clamp strobe monitor standing for the analog channels
module amc_partner #(parameter STROBE_CYC = 2) (
   input wire logic clock, run, clamp_strobe,
   output logic     sync_active,
   output int       short_runs, pulses, ends
);
   timeunit 1ns;
   timeprecision 1ns;
   int ph = 0, len = 0;
   initial {sync_active, short_runs, pulses, ends} = '0;
   always @(posedge clock) begin
      ph <= run ? (ph + 1) % 16 : 0;
      // A one-cycle and a five-cycle sync pulse per line pair
      sync_active <= run && (ph == 0 || (ph >= 8 && ph < 13));
      if (run && (ph == 0 || ph == 8)) pulses <= pulses + 1;
      len <= clamp_strobe ? len + 1 : 0;
      if (!clamp_strobe && len > 0) begin
         ends <= ends + 1;
         if (len < STROBE_CYC) short_runs <= short_runs + 1;
      end
   end
endmodule

// ### amc_tb.sv
// Self-checking bench of the front-end routing and clamp block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rv, v;
   logic sync_active, clamp_strobe, clamp_target_valid, second_converter_alternate, sound_if_route_sel, adc2_sample_third;
   logic [2:0] first_channel_input_sel, clamp_enable, impedance_boost_en, clamp_type, clamp_voltage_code;
   logic [1:0] second_channel_input_sel, third_channel_input_sel;
   logic [9:0] clamp_target_code;
   logic [15:0] lf = 16'h928F;
   int failures = 0, n_compared = 0, short_runs, pulses, ends;
   amc_afe_mux_clamp #(.STROBE_CYC(2)) amc_afe_mux_clamp_i (.*);
   amc_partner #(.STROBE_CYC(2)) amc_partner_i (.*);
   initial forever #25 clock = ~clock;
   function automatic logic [9:0] tgt(input logic [2:0] c);
      logic [9:0] t [8] = '{10'h000, 10'h000, 10'h07C, 10'h0DA, 10'h121, 10'h157, 10'h180, 10'h200};
      return t[c];
   endfunction
   task automatic rnd;
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      v = lf[7:0];
   endtask
   task automatic chk(input logic [15:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clock) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clock) reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task automatic settle;
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic print_verdict;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      print_verdict;
   end
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      settle;
      chk({clamp_enable, second_converter_alternate}, 4'hF);
      rd(12'h103); chk(rv, 8'hD3);
      rd(12'h105); chk(rv, 8'h33);
      rd(12'h106); chk(rv, 8'h0F);
      rd(12'h200); chk(rv, 8'h00);
      rd(12'h110); chk(rv[1:0], 2'h2);
      chk(clamp_voltage_code, 3'h3);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         rnd;
         if (i < 2) v = i ? 8'h51 : 8'h00;
         wr(12'h103, v); settle;
         chk({third_channel_input_sel, second_channel_input_sel, first_channel_input_sel}, {v[7:4], v[2:0]});
         rd(12'h103); chk({rv[7:4], rv[2:0]}, {v[7:4], v[2:0]});
      end
      for (int i = 0; i < 8; i++) begin
         rnd; v[7] = 1'b1;
         wr(12'h106, v); settle;
         chk({clamp_enable, impedance_boost_en}, {v[1:0], 1'b1, v[4:2]});
         chk({second_converter_alternate, sound_if_route_sel}, {v[5], v[6]});
      end
      $display("test route and boost done");
      for (int c = 0; c < 8; c++) begin
         wr(12'h105, {5'h08, c[2:0]}); settle;
         chk({clamp_voltage_code, clamp_target_valid, clamp_target_code}, {c[2:0], c != 0, tgt(c[2:0])});
         chk({clamp_type, clamp_enable[0]}, 4'h4);
      end
      wr(12'h103, 8'h00); settle;
      wr(12'h106, 8'hE0); settle;
      chk({clamp_enable[2:1], impedance_boost_en[2:1], second_converter_alternate, sound_if_route_sel}, 6'h03);
      run <= 1'b1;
      repeat (300) @(posedge clock);
      run <= 1'b0;
      repeat (20) @(posedge clock);
      chk(16'(short_runs), 16'h0000);
      chk(16'(ends), 16'(pulses));
      $display("test level and strobe done");
      print_verdict;
   end
endmodule
